// File: dac_regs.svh
// register offsets, field positions, reset values and step sizes of the two-channel dma register set
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH

// byte offsets inside the block window; channel 1 sits 0x10 above channel 0
`define DAC_OFS_SRC 4'h0
`define DAC_OFS_DST 4'h4
`define DAC_OFS_CNT 4'h8
`define DAC_OFS_CTL 4'hc
`define DAC_CH_STRIDE_BIT 4
`define DAC_ADDR_BITS 5

// control word fields
`define DAC_CTL_DST_MODE_HI 15
`define DAC_CTL_DST_MODE_LO 14
`define DAC_CTL_SRC_MODE_HI 13
`define DAC_CTL_SRC_MODE_LO 12
`define DAC_CTL_SIZE_HI 11
`define DAC_CTL_SIZE_LO 10
`define DAC_CTL_AUTO_REQ 9
`define DAC_CTL_ACK_MODE 8
`define DAC_CTL_REQ_LEVEL 5
`define DAC_CTL_SINGLE 3
`define DAC_CTL_END_FLAG 1
`define DAC_CTL_ENABLE 0
`define DAC_CTL_WIDTH 16
`define DAC_CTL_RESET 16'h0000

// count field
`define DAC_CNT_WIDTH 24
`define DAC_CNT_STEP_UNIT 24'h000001
`define DAC_CNT_STEP_BLOCK 24'h000004

// address steps per transfer unit
`define DAC_STEP_BYTE 32'h00000001
`define DAC_STEP_WORD 32'h00000002
`define DAC_STEP_LONG 32'h00000004
`define DAC_STEP_BLOCK 32'h00000010

`endif

// File: dac_pkg.sv
// types shared by the two-channel dma register set
package dac_pkg;

  typedef enum logic [1:0] {
    DAC_STEP_FIXED,
    DAC_STEP_INC,
    DAC_STEP_DEC,
    DAC_STEP_BAD
  } dac_step_e;

  typedef enum logic [1:0] {
    DAC_SIZE_BYTE,
    DAC_SIZE_WORD,
    DAC_SIZE_LONG,
    DAC_SIZE_BLOCK
  } dac_size_e;

endpackage

// File: dac_channel_regs.sv
// two-channel dma address, count and control registers with an ahb-lite slave port
//
// Contract
// [RULE_01] source address register is 32 bits and shows the next source access address
// [RULE_02] single mode, device-to-memory: source address register is not used
// [RULE_03] software aligns the source address to 16 bytes for 16-byte units
// [RULE_04] software uses 16-byte units only with auto or edge-detected requests
// [RULE_05] address and count registers keep contents through reset and both standbys
// [RULE_06] destination address register is 32 bits and shows the next destination address
// [RULE_07] single mode, memory-to-device: destination address register is not used
// [RULE_08] software aligns the destination to 16 bytes for 16-byte units to sdram
// [RULE_09] count uses low 24 bits; upper eight read zero, software writes zero
// [RULE_10] count one means one transfer; zero means 16,777,216 transfers
// [RULE_11] during a transfer the count register shows transfers remaining
// [RULE_12] software loads four times the unit count for 16-byte transfers
// [RULE_13] control uses low 16 bits; upper read zero, software writes zero
// [RULE_14] control clears on reset and standby entry, keeps value in module standby
// [RULE_15] transfer end flag is cleared by writing zero; writing one does nothing
// [RULE_16] destination mode fixed, increment or decrement by 1, 2, 4 or 16
// [RULE_17] single mode, memory-to-device: destination mode field is ignored
// [RULE_18] source mode fixed, increment or decrement; 16-byte units always add 16
// [RULE_19] single mode, device-to-memory: source mode field is ignored
// [RULE_20] size field selects byte, word, longword or 16-byte unit of four longwords
// [RULE_21] auto request bit one selects internal requests, zero selects pin or peripheral
// [RULE_22] each completed 16-byte unit takes four off the remaining count
// [RULE_23] address registers step after each completed unit to show next access
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "dac_regs.svh"

module dac_channel_regs
  import dac_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic standby,
  input wire logic module_standby,
  input wire logic [NUM_CH-1:0] transfer_request_pin,
  input wire logic [NUM_CH-1:0] unit_done,
  output logic [NUM_CH-1:0] channel_request,
  output logic [NUM_CH-1:0] use_source,
  output logic [NUM_CH-1:0] use_destination,
  output logic [NUM_CH-1:0][1:0] unit_size,
  output logic [NUM_CH-1:0][31:0] source_address_reg,
  output logic [NUM_CH-1:0][31:0] destination_address_reg
);

  logic [NUM_CH-1:0][`DAC_CNT_WIDTH-1:0] transfer_count_reg;
  logic [NUM_CH-1:0][`DAC_CTL_WIDTH-1:0] channel_control_reg;
  logic [NUM_CH-1:0] req_meta;
  logic [NUM_CH-1:0] req_sync;
  logic wr_pend;
  logic rd_pend;
  logic [`DAC_ADDR_BITS-1:0] a_addr;
  logic a_valid;
  logic [NUM_CH-1:0] running;
  logic [NUM_CH-1:0] step_now;
  logic [NUM_CH-1:0] single_to_mem;
  logic [NUM_CH-1:0] single_to_dev;
  logic [NUM_CH-1:0][`DAC_CNT_WIDTH-1:0] cnt_dec;
  logic [NUM_CH-1:0] wr_src;
  logic [NUM_CH-1:0] wr_dst;
  logic [NUM_CH-1:0] wr_cnt;
  logic [NUM_CH-1:0] wr_ctl;

  // address step by unit size and mode; the 16-byte source always advances
  function automatic logic [31:0] dac_next_addr(input logic [31:0] addr,
                                               input logic [1:0] mode,
                                               input logic [1:0] size,
                                               input logic force_inc);
    logic [31:0] step;
    step = `DAC_STEP_BYTE;
    case (dac_size_e'(size))
      DAC_SIZE_BYTE: step = `DAC_STEP_BYTE;
      DAC_SIZE_WORD: step = `DAC_STEP_WORD;
      DAC_SIZE_LONG: step = `DAC_STEP_LONG;
      DAC_SIZE_BLOCK: step = `DAC_STEP_BLOCK;
      default: step = `DAC_STEP_BYTE;
    endcase
    if (force_inc && dac_size_e'(size) == DAC_SIZE_BLOCK) begin
      dac_next_addr = addr + step;
    end else begin
      case (dac_step_e'(mode))
        DAC_STEP_INC: dac_next_addr = addr + step;
        DAC_STEP_DEC: dac_next_addr = addr - step;
        // fixed, and the prohibited code also holds the address
        default: dac_next_addr = addr;
      endcase
    end
  endfunction

  // decode of the latched data-phase address for one channel and one register
  function automatic logic dac_hit(input logic [`DAC_ADDR_BITS-1:0] addr,
                                   input int ch,
                                   input logic [3:0] ofs);
    dac_hit = (addr[`DAC_CH_STRIDE_BIT] == ch[0]) && (addr[3:0] == ofs);
  endfunction

  // ahb address phase and slave handshake
  assign a_valid = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      a_addr <= '0;
    end else begin
      wr_pend <= a_valid && hwrite;
      rd_pend <= a_valid && !hwrite;
      if (a_valid) begin
        a_addr <= haddr[`DAC_ADDR_BITS-1:0];
      end
    end
  end

  // reads take one wait state because hrdata is registered during the first data-phase cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(a_valid && !hwrite);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend) begin
      hrdata <= 32'h00000000;
      for (int c = 0; c < NUM_CH; c++) begin
        if (dac_hit(a_addr, c, `DAC_OFS_SRC)) begin
          hrdata <= source_address_reg[c];
        end
        if (dac_hit(a_addr, c, `DAC_OFS_DST)) begin
          hrdata <= destination_address_reg[c];
        end
        if (dac_hit(a_addr, c, `DAC_OFS_CNT)) begin
          hrdata <= {8'h00, transfer_count_reg[c]}; // [RULE_09] [RULE_11]
        end
        if (dac_hit(a_addr, c, `DAC_OFS_CTL)) begin
          hrdata <= {16'h0000, channel_control_reg[c]}; // [RULE_13]
        end
      end
    end
  end

  // request pins come from outside, so two flops before anything reads them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_meta <= '0;
      req_sync <= '0;
    end else begin
      req_meta <= transfer_request_pin;
      req_sync <= req_meta;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      running[c] = channel_control_reg[c][`DAC_CTL_ENABLE] &&
                   !channel_control_reg[c][`DAC_CTL_END_FLAG];
      step_now[c] = running[c] && unit_done[c];
      single_to_mem[c] = channel_control_reg[c][`DAC_CTL_SINGLE] &&
                         channel_control_reg[c][`DAC_CTL_ACK_MODE];
      single_to_dev[c] = channel_control_reg[c][`DAC_CTL_SINGLE] &&
                         !channel_control_reg[c][`DAC_CTL_ACK_MODE];
      // [RULE_20] [RULE_22] a 16-byte unit is four longwords of count
      cnt_dec[c] = (channel_control_reg[c][`DAC_CTL_SIZE_HI:`DAC_CTL_SIZE_LO] ==
                    2'(DAC_SIZE_BLOCK)) ? `DAC_CNT_STEP_BLOCK : `DAC_CNT_STEP_UNIT;
      wr_src[c] = wr_pend && dac_hit(a_addr, c, `DAC_OFS_SRC);
      wr_dst[c] = wr_pend && dac_hit(a_addr, c, `DAC_OFS_DST);
      wr_cnt[c] = wr_pend && dac_hit(a_addr, c, `DAC_OFS_CNT);
      wr_ctl[c] = wr_pend && dac_hit(a_addr, c, `DAC_OFS_CTL);
    end
  end

  // address registers have no reset: they keep their value through every reset
  always_ff @(posedge hclk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_src[c]) begin
        source_address_reg[c] <= hwdata; // [RULE_01] [RULE_05]
      end else if (step_now[c] && !single_to_mem[c]) begin // [RULE_02] [RULE_19]
        source_address_reg[c] <= dac_next_addr(source_address_reg[c],
          channel_control_reg[c][`DAC_CTL_SRC_MODE_HI:`DAC_CTL_SRC_MODE_LO],
          channel_control_reg[c][`DAC_CTL_SIZE_HI:`DAC_CTL_SIZE_LO], 1'b1); // [RULE_18] [RULE_23]
      end
    end
  end

  always_ff @(posedge hclk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_dst[c]) begin
        destination_address_reg[c] <= hwdata; // [RULE_06] [RULE_05]
      end else if (step_now[c] && !single_to_dev[c]) begin // [RULE_07] [RULE_17]
        destination_address_reg[c] <= dac_next_addr(destination_address_reg[c],
          channel_control_reg[c][`DAC_CTL_DST_MODE_HI:`DAC_CTL_DST_MODE_LO],
          channel_control_reg[c][`DAC_CTL_SIZE_HI:`DAC_CTL_SIZE_LO], 1'b0); // [RULE_16] [RULE_23]
      end
    end
  end

  // zero wraps to all ones, or to 0xfffffc for 16-byte units, so a loaded zero runs the full 2^24 transfers
  always_ff @(posedge hclk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_cnt[c]) begin
        transfer_count_reg[c] <= hwdata[`DAC_CNT_WIDTH-1:0]; // [RULE_09] [RULE_05]
      end else if (step_now[c]) begin
        transfer_count_reg[c] <= transfer_count_reg[c] - cnt_dec[c]; // [RULE_10] [RULE_11]
      end
    end
  end

  // the end flag is set when the count reaches zero; a set beats a clearing write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NUM_CH; c++) begin
        channel_control_reg[c] <= `DAC_CTL_RESET; // [RULE_14]
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (standby) begin
          channel_control_reg[c] <= `DAC_CTL_RESET; // [RULE_14]
        end else begin
          if (wr_ctl[c]) begin
            channel_control_reg[c][`DAC_CTL_WIDTH-1:2] <= hwdata[`DAC_CTL_WIDTH-1:2];
            channel_control_reg[c][`DAC_CTL_ENABLE] <= hwdata[`DAC_CTL_ENABLE];
          end
          if (step_now[c] && transfer_count_reg[c] == cnt_dec[c]) begin
            channel_control_reg[c][`DAC_CTL_END_FLAG] <= 1'b1;
          end else if (wr_ctl[c] && !hwdata[`DAC_CTL_END_FLAG]) begin
            channel_control_reg[c][`DAC_CTL_END_FLAG] <= 1'b0; // [RULE_15]
          end
        end
      end
    end
  end

  // engine-facing status; module standby only freezes the engine, registers hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_request <= '0;
      use_source <= '0;
      use_destination <= '0;
      unit_size <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        channel_request[c] <= running[c] && !module_standby && !standby &&
          (channel_control_reg[c][`DAC_CTL_AUTO_REQ] ||
           (req_sync[c] == channel_control_reg[c][`DAC_CTL_REQ_LEVEL])); // [RULE_21]
        use_source[c] <= !single_to_mem[c]; // [RULE_02]
        use_destination[c] <= !single_to_dev[c]; // [RULE_07]
        unit_size[c] <= channel_control_reg[c][`DAC_CTL_SIZE_HI:`DAC_CTL_SIZE_LO]; // [RULE_20]
      end
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    te_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_10]
      step_now[g] && !standby && transfer_count_reg[g] == cnt_dec[g]
      |=> channel_control_reg[g][`DAC_CTL_END_FLAG])
      else $error("end flag not set at count zero");

    te_write_one_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_15]
      wr_ctl[g] && hwdata[`DAC_CTL_END_FLAG] && !channel_control_reg[g][`DAC_CTL_END_FLAG]
      && !step_now[g] |=> !channel_control_reg[g][`DAC_CTL_END_FLAG])
      else $error("writing one changed the end flag");

    cnt_step_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_22]
      step_now[g] && !wr_cnt[g] && channel_control_reg[g][11:10] == 2'b11
      |=> transfer_count_reg[g] == $past(transfer_count_reg[g]) - 24'h000004)
      else $error("16-byte unit did not take four from count");

    src_block_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_18]
      step_now[g] && !wr_src[g] && !single_to_mem[g] && channel_control_reg[g][11:10] == 2'b11
      |=> source_address_reg[g] == $past(source_address_reg[g]) + 32'h00000010)
      else $error("16-byte source did not advance by 16");

    dst_dec_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_16]
      step_now[g] && !wr_dst[g] && !single_to_dev[g] && channel_control_reg[g][15:14] == 2'b10
      && channel_control_reg[g][11:10] == 2'b01
      |=> destination_address_reg[g] == $past(destination_address_reg[g]) - 32'h00000002)
      else $error("word destination did not step down by two");

    src_skip_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_19]
      step_now[g] && single_to_mem[g] && !wr_src[g] |=> $stable(source_address_reg[g]))
      else $error("source moved in single device-to-memory mode");

    dst_skip_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_17]
      step_now[g] && single_to_dev[g] && !wr_dst[g] |=> $stable(destination_address_reg[g]))
      else $error("destination moved in single memory-to-device mode");

    standby_clr_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_14]
      standby && !wr_cnt[g] |=> channel_control_reg[g] == 16'h0000
      && transfer_count_reg[g] == $past(transfer_count_reg[g]))
      else $error("standby did not clear control or disturbed count");

    src_inc_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_18]
      step_now[g] && !wr_src[g] && !single_to_mem[g] && channel_control_reg[g][13:10] == 4'h5
      |=> source_address_reg[g] == $past(source_address_reg[g]) + 32'h00000002)
      else $error("word source did not step up by two");

    src_dec_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_18]
      step_now[g] && !wr_src[g] && !single_to_mem[g] && channel_control_reg[g][13:10] == 4'ha
      |=> source_address_reg[g] == $past(source_address_reg[g]) - 32'h00000004)
      else $error("longword source did not step down by four");

    dst_inc_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_16]
      step_now[g] && !wr_dst[g] && !single_to_dev[g] && channel_control_reg[g][15:14] == 2'h1
      && channel_control_reg[g][11:10] == 2'h2
      |=> destination_address_reg[g] == $past(destination_address_reg[g]) + 32'h00000004)
      else $error("longword destination did not step up by four");

    dst_fixed_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_16]
      step_now[g] && !wr_dst[g] && channel_control_reg[g][15:14] == 2'h0
      |=> $stable(destination_address_reg[g]))
      else $error("fixed destination moved");

    cnt_unit_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_11]
      step_now[g] && !wr_cnt[g] && channel_control_reg[g][11:10] != 2'h3
      |=> transfer_count_reg[g] == $past(transfer_count_reg[g]) - 24'h000001)
      else $error("unit did not take one from count");

    req_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_21]
      !running[g] |=> !channel_request[g])
      else $error("request raised by a channel that is not running");

    auto_req_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_21]
      running[g] && channel_control_reg[g][9] && !standby && !module_standby
      |=> channel_request[g])
      else $error("auto request missing on a running channel");

    use_src_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_02]
      single_to_mem[g] |=> !use_source[g])
      else $error("source marked in use for device-to-memory");

    use_dst_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_07]
      single_to_dev[g] |=> !use_destination[g])
      else $error("destination marked in use for memory-to-device");

    size_copy_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_20]
      1'b1 |=> unit_size[g] == $past(channel_control_reg[g][11:10]))
      else $error("unit size output lags the size field");
  end

  rd_upper_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_09]
    rd_pend && a_addr[3:0] == 4'h8 |=> hrdata[31:24] == 8'h00 && hreadyout)
    else $error("count upper byte not zero on read");

  rd_wait_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_13]
    a_valid && !hwrite |=> !hreadyout ##1 hreadyout
      && (hrdata[31:16] == 16'h0000 || a_addr[3:0] != 4'hc))
    else $error("read wait state or control upper half wrong");

endmodule

// File: dac_engine_model.sv
// bus engine stand-in: answers channel requests with one-cycle unit completion pulses
`timescale 1ns/1ns

module dac_engine_model #(
  parameter int NUM_CH = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic [NUM_CH-1:0] channel_request,
  output logic [NUM_CH-1:0] unit_done
);
  int gap [NUM_CH];

  // the gap lets the registered request reflect a finished count before the next pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_done <= '0;
      foreach (gap[c]) gap[c] <= 0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        unit_done[c] <= 1'b0;
        if (gap[c] > 0) begin
          gap[c] <= gap[c] - 1;
        end else if (channel_request[c] && !unit_done[c]) begin
          unit_done[c] <= 1'b1;
          gap[c] <= slow ? 6 : 2;
        end
      end
    end
  end
endmodule

// File: dac_channel_regs_tb_top.sv
// self-checking bench for the two-channel dma register set
`timescale 1ns/1ns

module dac_channel_regs_tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, standby = 0, module_standby = 0, slow = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, sv;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'b010;
  logic [1:0] pin = '0, unit_done, channel_request, use_source, use_destination;
  logic [1:0][1:0] unit_size;
  logic [1:0][31:0] src_q, dst_q;
  logic hreadyout, hresp;
  wire hready = hreadyout;
  int error_cnt = 0, check_count = 0, cyc = 0;
  logic [4:0] ra [8] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18, 5'h1c};
  logic [31:0] rw [8] = '{32'h12345678, 32'h9abcdef0, 32'h00abcdef, 32'h00005efa,
    32'h0000000f, 32'hfffffff0, 32'h00000001, 32'h0000a4b4};
  logic [31:0] re [8] = '{32'h12345678, 32'h9abcdef0, 32'h00abcdef, 32'h00005ef8,
    32'h0000000f, 32'hfffffff0, 32'h00000001, 32'h0000a4b4};

  always #5 hclk = ~hclk;

  dac_channel_regs #(.NUM_CH(2)) i_dac_channel_regs (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .standby(standby), .module_standby(module_standby), .transfer_request_pin(pin),
    .unit_done(unit_done), .channel_request(channel_request), .use_source(use_source),
    .use_destination(use_destination), .unit_size(unit_size), .source_address_reg(src_q),
    .destination_address_reg(dst_q));

  dac_engine_model #(.NUM_CH(2)) i_dac_engine_model (.hclk(hclk), .hresetn(hresetn),
    .slow(slow), .channel_request(channel_request), .unit_done(unit_done));

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask

  // ready and read data are taken at the rising edge, before that edge's updates land
  task automatic rdy;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input string m);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp, m);
  endtask

  task automatic wait_end(input logic [4:0] a);
    bus(a, 1'b0, 32'h0);
    repeat (300) if (rd[1] !== 1'b1) bus(a, 1'b0, 32'h0);
  endtask

  task automatic settle;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) bus(ra[i], 1'b1, rw[i]);
    for (int i = 0; i < 8; i++) rchk(ra[i], re[i], "row");
    chk(32'(hresp), 32'h0, "resp");
    chk(32'(unit_size[0]), 32'h3, "size blk");
    chk(32'(unit_size[1]), 32'h1, "size word");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(5'h00, 32'h12345678, "src kept");
    rchk(5'h08, 32'h00abcdef, "cnt kept");
    rchk(5'h0c, 32'h0, "ctl reset");
    bus(5'h1c, 1'b1, 32'h0000a4b4);
    module_standby <= 1'b1;
    repeat (4) @(posedge hclk);
    module_standby <= 1'b0;
    rchk(5'h1c, 32'h0000a4b4, "mstby kept");
    standby <= 1'b1;
    repeat (4) @(posedge hclk);
    standby <= 1'b0;
    rchk(5'h1c, 32'h0, "stby clr");
    rchk(5'h14, 32'hfffffff0, "stby dst");
    // longword run: source down, destination up, auto request
    bus(5'h00, 1'b1, 32'h00001000);
    bus(5'h04, 1'b1, 32'h00002000);
    bus(5'h08, 1'b1, 32'h00000003);
    bus(5'h0c, 1'b1, 32'h00006a01);
    wait_end(5'h0c);
    chk(rd, 32'h00006a03, "end flag");
    rchk(5'h00, 32'h00000ff4, "src dec");
    rchk(5'h04, 32'h0000200c, "dst inc");
    rchk(5'h08, 32'h0, "cnt done");
    chk(src_q[0], 32'h00000ff4, "src port");
    chk(dst_q[0], 32'h0000200c, "dst port");
    chk(32'(channel_request[0]), 32'h0, "req off");
    // 16-byte run on a slow engine, source mode fixed yet stepping by 16
    slow <= 1'b1;
    bus(5'h10, 1'b1, 32'h00003000);
    bus(5'h14, 1'b1, 32'h00004000);
    bus(5'h18, 1'b1, 32'h00000008);
    bus(5'h1c, 1'b1, 32'h00008e01);
    wait_end(5'h1c);
    chk(rd, 32'h00008e03, "blk flag");
    rchk(5'h10, 32'h00003020, "blk src");
    rchk(5'h14, 32'h00003fe0, "blk dst");
    rchk(5'h18, 32'h0, "blk cnt");
    bus(5'h1c, 1'b1, 32'h00008e02);
    rchk(5'h1c, 32'h00008e02, "flag w1");
    bus(5'h1c, 1'b1, 32'h00008e00);
    rchk(5'h1c, 32'h00008e00, "flag w0");
    bus(5'h0c, 1'b1, 32'h00000108);
    settle();
    chk({30'h0, use_source[0], use_destination[0]}, 32'h1, "dev2mem");
    @(posedge hclk);
    bus(5'h0c, 1'b1, 32'h00000008);
    settle();
    chk({30'h0, use_source[0], use_destination[0]}, 32'h2, "mem2dev");
    @(posedge hclk);
    // single address runs: the acknowledged side keeps its address register
    bus(5'h00, 1'b1, 32'h00000500);
    bus(5'h04, 1'b1, 32'h00000600);
    bus(5'h08, 1'b1, 32'h00000002);
    bus(5'h0c, 1'b1, 32'h00009709);
    wait_end(5'h0c);
    chk(rd, 32'h0000970b, "sgl flag");
    rchk(5'h00, 32'h00000500, "s dev2mem");
    rchk(5'h04, 32'h000005fc, "d dev2mem");
    bus(5'h08, 1'b1, 32'h00000002);
    bus(5'h0c, 1'b1, 32'h00009609);
    wait_end(5'h0c);
    rchk(5'h00, 32'h00000504, "s mem2dev");
    rchk(5'h04, 32'h000005fc, "d mem2dev");
    // zero count means the maximum, so it wraps and never ends here; pin driven requests
    slow <= 1'b0;
    bus(5'h00, 1'b1, 32'h00000100);
    bus(5'h08, 1'b1, 32'h00000000);
    bus(5'h0c, 1'b1, 32'h00001021);
    pin[0] <= 1'b1;
    repeat (30) @(posedge hclk);
    pin[0] <= 1'b0;
    repeat (10) @(posedge hclk);
    bus(5'h00, 1'b0, 32'h0);
    sv = rd - 32'h00000100;
    chk(32'(sv != 32'h0), 32'h1, "moved");
    rchk(5'h08, {8'h0, 24'h0 - sv[23:0]}, "cnt wrap");
    rchk(5'h0c, 32'h00001021, "no end");
    rchk(5'h00, sv + 32'h00000100, "pin idle");
    wrap_up();
  end
endmodule
